// ===== pkg/wdsc_consts.vh
// Purpose: constants for wdsc_top
// Assumes: included by bare name; byte address is four times the index
// Notes: indices are compared against address bits [15:2]
`ifndef WDSC_CONSTS_VH
`define WDSC_CONSTS_VH

// ----
// register indices, byte address 4 x index
// ----
`define WDSC_IDX_STATUS 14'h0003
`define WDSC_IDX_TMRCFG 14'h0081
`define WDSC_IDX_CFGWORD 14'h2007

// ----
// field positions
// ----
`define WDSC_TMRCFG_ASG 3
`define WDSC_TMRCFG_PS_MSB 2
`define WDSC_CFG_WDT_EN 2
`define WDSC_STATUS_TMO 4
`define WDSC_STATUS_PWD 3

// ----
// reset values
// ----
`define WDSC_TMRCFG_RST 8'h00
`define WDSC_CFGWORD_RST 8'h00
`define WDSC_FLAG_RST 1'h1

// ----
// bus answers
// ----
`define WDSC_RESP_OKAY 2'h0
`define WDSC_RESP_SLVERR 2'h2

// ----
// timing
// ----
`define WDSC_CLK_MHZ 100
`define WDSC_WDT_PERIOD_MS 18
`define WDSC_WDT_PERIOD_CYC (`WDSC_WDT_PERIOD_MS * 1000 * `WDSC_CLK_MHZ)

`endif

// ===== hw/wdsc_top.v
// Purpose: watchdog timer and power-down (sleep) control
// Assumes: core pulses are one cycle wide and synchronous to i_sys_clk
// Notes: registers reached over AXI4-Lite, 16-bit byte address
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "wdsc_consts.vh"

// Functional notes
// (RULE_01) watchdog time base never stops with core clock
// (RULE_02) time-out while running resets the device
// (RULE_03) time-out while asleep wakes the device
// (RULE_04) fuse bit 2 cleared disables watchdog
// (RULE_05) undivided time-out about 18 ms
// (RULE_06) software sets prescaler rate, up to 1:128
// (RULE_07) select bit one: prescaler divides watchdog
// (RULE_08) clear or sleep instruction zeroes watchdog counts
// (RULE_09) clear keeps prescaler assignment, zeroes count
// (RULE_10) any time-out clears timeout flag
// (RULE_11) sleep: clear watchdog, flags, stop oscillator
// (RULE_12) port drive states frozen during sleep
// (RULE_13) powerdown flag set at power-up, cleared by sleep
// (RULE_14) wake on reset pin, watchdog, enabled interrupt
// (RULE_15) only sleep-capable interrupt sources wake
// (RULE_16) next instruction prefetched while sleep executes
// (RULE_17) individual enable wakes regardless of global enable
// (RULE_18) wake then vector only if global enable set
// (RULE_19) pending enabled interrupt makes sleep a no-op
// (RULE_20) interrupt during sleep: finish effects, wake
module wdsc_top #(
    parameter N_INT = 8,
    parameter N_PIN = 8,
    parameter [N_INT-1:0] WAKE_MASK = 8'hff,
    parameter CNT_W = 21,
    parameter WDT_PERIOD_CYC = `WDSC_WDT_PERIOD_CYC
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_rst_n,
    // axi4-lite write address
    input wire [15:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output wire o_s_axi_awready,
    // axi4-lite write data
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output wire o_s_axi_wready,
    // axi4-lite write response
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    // axi4-lite read address
    input wire [15:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output wire o_s_axi_arready,
    // axi4-lite read data
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    // fuses
    input wire [7:0] i_config_word,
    // core instruction strobes
    input wire i_watchdog_clear_instruction,
    input wire i_sleep_instruction,
    // reset pin and interrupts
    input wire i_master_reset_pin_n,
    input wire [N_INT-1:0] i_int_flag,
    input wire [N_INT-1:0] i_int_enable,
    input wire i_global_interrupt_enable,
    // core control outputs
    output reg o_wdt_reset,
    output reg o_master_reset,
    output reg o_sleeping,
    output reg o_osc_run,
    output reg o_prefetch,
    output reg o_sleep_nop,
    output reg o_wake,
    output reg o_wake_vector,
    // prescaler routing
    output reg o_prescaler_to_timer,
    output reg [2:0] o_prescaler_rate_select,
    // port pins
    input wire [N_PIN-1:0] i_port_out,
    input wire [N_PIN-1:0] i_port_oe_n,
    output wire [N_PIN-1:0] o_pin_out,
    output wire [N_PIN-1:0] o_pin_oe_n
);

    // ----
    // states and derived counts
    // ----
    localparam ST_RUN = 1'b0; // core clock running
    localparam ST_SLEEP = 1'b1; // oscillator driver off
    localparam [31:0] PER_M1 = WDT_PERIOD_CYC - 1; // last base count

    // ----
    // storage
    // ----
    reg state; // power state
    reg [7:0] timer_config_register; // software rate and assignment
    reg [7:0] device_configuration_word; // fuse copy
    reg cfg_loaded; // fuse copy taken
    reg timeout_status_flag; // active low
    reg powerdown_status_flag; // active low
    reg [CNT_W-1:0] base_cnt; // watchdog time base
    reg [6:0] post_cnt; // prescaler count
    reg aw_full; // write address held
    reg w_full; // write data held
    reg [13:0] aw_idx; // held write index
    reg [7:0] w_byte; // held low data byte
    reg w_lane0; // low byte strobe held
    reg [N_PIN-1:0] hold_out; // frozen pin levels
    reg [N_PIN-1:0] hold_oe_n; // frozen pin enables

    // ----
    // decoded controls
    // ----
    wire watchdog_enable_fuse;
    wire prescaler_assign_select;
    wire [2:0] prescaler_rate_select;
    wire [6:0] post_max;
    wire int_pending;
    wire irq_wake;
    wire sleep_go;
    wire wdt_clr;
    wire base_done;
    wire timeout;

    // fuse disables the counter outright
    assign watchdog_enable_fuse = device_configuration_word[`WDSC_CFG_WDT_EN]; // RULE_04
    assign prescaler_assign_select = timer_config_register[`WDSC_TMRCFG_ASG];
    assign prescaler_rate_select = timer_config_register[`WDSC_TMRCFG_PS_MSB:0]; // RULE_06
    // ratio 1:2^rate, last count 2^rate - 1
    assign post_max = 7'h7f >> (3'h7 - prescaler_rate_select); // RULE_06

    // any enabled flag, global enable ignored
    assign int_pending = |(i_int_flag & i_int_enable); // RULE_17
    // only sources that run without phase clocks may wake
    assign irq_wake = |(i_int_flag & i_int_enable & WAKE_MASK); // RULE_15

    // sleep only when nothing enabled is pending
    assign sleep_go = i_sleep_instruction && (state == ST_RUN) && !int_pending; // RULE_19

    // clear sources of the counter chain
    assign wdt_clr = i_watchdog_clear_instruction || sleep_go || !watchdog_enable_fuse ||
                     !i_master_reset_pin_n; // RULE_08

    // base counter wraps every nominal period
    assign base_done = !wdt_clr && (base_cnt == PER_M1[CNT_W-1:0]); // RULE_05

    // undivided unless the prescaler belongs to the watchdog
    assign timeout = base_done && (!prescaler_assign_select || post_cnt == post_max); // RULE_07

    // ----
    // fuse capture
    // ----
    // fuses sampled once, after reset release
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            device_configuration_word <= `WDSC_CFGWORD_RST;
            cfg_loaded <= 1'b0;
        end else if (!cfg_loaded) begin
            device_configuration_word <= i_config_word;
            cfg_loaded <= 1'b1;
        end
    end

    // ----
    // watchdog counter chain
    // ----
    // counts on every edge in any power state,
    // standing in for the separate rc time base
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            base_cnt <= {CNT_W{1'b0}};
        end else if (wdt_clr) begin
            base_cnt <= {CNT_W{1'b0}}; // RULE_08
        end else if (base_done) begin
            base_cnt <= {CNT_W{1'b0}};
        end else begin
            base_cnt <= base_cnt + 1'b1; // RULE_01
        end
    end

    // prescaler count; clearing never touches the assignment bit
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            post_cnt <= 7'h00;
        end else if (wdt_clr || !prescaler_assign_select) begin
            post_cnt <= 7'h00; // RULE_09
        end else if (base_done) begin
            // wrap at the selected ratio
            if (post_cnt == post_max) begin
                post_cnt <= 7'h00;
            end else begin
                post_cnt <= post_cnt + 7'h01;
            end
        end
    end

    // ----
    // power state machine and flags
    // ----
    // one process owns state, flags and core strobes
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_RUN;
            timeout_status_flag <= `WDSC_FLAG_RST;
            powerdown_status_flag <= `WDSC_FLAG_RST; // RULE_13
            o_wdt_reset <= 1'b0;
            o_master_reset <= 1'b0;
            o_sleeping <= 1'b0;
            o_osc_run <= 1'b1;
            o_prefetch <= 1'b0;
            o_sleep_nop <= 1'b0;
            o_wake <= 1'b0;
            o_wake_vector <= 1'b0;
        end else begin
            // strobes default low
            o_wdt_reset <= 1'b0;
            o_prefetch <= 1'b0;
            o_sleep_nop <= 1'b0;
            o_wake <= 1'b0;
            o_master_reset <= !i_master_reset_pin_n;
            // any time-out marks the flag, running or asleep
            if (timeout) begin
                timeout_status_flag <= 1'b0; // RULE_10
            end
            case (state)
                ST_RUN: begin
                    if (!i_master_reset_pin_n) begin
                        // reset pin holds the core, no sleep entry
                        state <= ST_RUN;
                    end else if (timeout) begin
                        o_wdt_reset <= 1'b1; // RULE_02
                    end else if (sleep_go) begin
                        // full side effects before any wake
                        state <= ST_SLEEP; // RULE_20
                        timeout_status_flag <= 1'b1; // RULE_11
                        powerdown_status_flag <= 1'b0; // RULE_11
                        o_sleeping <= 1'b1;
                        o_osc_run <= 1'b0; // RULE_11
                        o_prefetch <= 1'b1; // RULE_16
                    end else if (i_sleep_instruction) begin
                        // pending interrupt: no flag or counter change
                        o_sleep_nop <= 1'b1; // RULE_19
                        o_prefetch <= 1'b1; // RULE_16
                    end
                end
                ST_SLEEP: begin
                    if (!i_master_reset_pin_n) begin
                        // reset pin ends sleep by resetting the device
                        state <= ST_RUN; // RULE_14
                        o_sleeping <= 1'b0;
                        o_osc_run <= 1'b1;
                    end else if (timeout || irq_wake) begin
                        // continuation, not a reset
                        state <= ST_RUN; // RULE_03
                        o_sleeping <= 1'b0;
                        o_osc_run <= 1'b1;
                        o_wake <= 1'b1; // RULE_14
                        // vector after the prefetched instruction
                        o_wake_vector <= irq_wake && i_global_interrupt_enable; // RULE_18
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // ----
    // pin hold per bit
    // ----
    genvar gi;
    generate
        for (gi = 0; gi < N_PIN; gi = gi + 1) begin : g_pin
            // follow core while running, freeze asleep
            always @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    hold_out[gi] <= 1'b0;
                    hold_oe_n[gi] <= 1'b1;
                end else if (state == ST_RUN && !sleep_go) begin
                    hold_out[gi] <= i_port_out[gi];
                    hold_oe_n[gi] <= i_port_oe_n[gi];
                end
            end
            // frozen copy drives the pin, high-z stays high-z
            assign o_pin_out[gi] = hold_out[gi]; // RULE_12
            assign o_pin_oe_n[gi] = hold_oe_n[gi]; // RULE_12
        end
    endgenerate

    // ----
    // prescaler routing outputs
    // ----
    // other timer owns the prescaler when select is zero
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prescaler_to_timer <= 1'b1;
            o_prescaler_rate_select <= 3'h0;
        end else begin
            o_prescaler_to_timer <= !prescaler_assign_select; // RULE_07
            o_prescaler_rate_select <= prescaler_rate_select;
        end
    end

    // ----
    // axi4-lite write path
    // ----
    // address and data taken apart, one slot each;
    // answer waits for both: one write per two edges
    assign o_s_axi_awready = !aw_full;
    assign o_s_axi_wready = !w_full;

    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_idx <= 14'h0000;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `WDSC_RESP_OKAY;
            timer_config_register <= `WDSC_TMRCFG_RST;
        end else begin
            // capture address
            if (i_s_axi_awvalid && !aw_full) begin
                aw_full <= 1'b1;
                aw_idx <= i_s_axi_awaddr[15:2];
            end
            // capture data
            if (i_s_axi_wvalid && !w_full) begin
                w_full <= 1'b1;
                w_byte <= i_s_axi_wdata[7:0];
                w_lane0 <= i_s_axi_wstrb[0];
            end
            // commit once both are held and no answer is open
            if (aw_full && w_full && !o_s_axi_bvalid) begin
                o_s_axi_bvalid <= 1'b1;
                aw_full <= 1'b0;
                w_full <= 1'b0;
                if (aw_idx == `WDSC_IDX_TMRCFG) begin
                    o_s_axi_bresp <= `WDSC_RESP_OKAY;
                    if (w_lane0) begin
                        timer_config_register <= w_byte; // RULE_06
                    end
                end else begin
                    // read-only or unmapped
                    o_s_axi_bresp <= `WDSC_RESP_SLVERR;
                end
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----
    // axi4-lite read path
    // ----
    // one read at a time; next address once data is taken
    assign o_s_axi_arready = !o_s_axi_rvalid;

    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `WDSC_RESP_OKAY;
        end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rresp <= `WDSC_RESP_OKAY;
            case (i_s_axi_araddr[15:2])
                `WDSC_IDX_STATUS: begin
                    // status shows both active-low flags
                    o_s_axi_rdata <= {27'h0000000, timeout_status_flag, powerdown_status_flag,
                                      3'h0};
                end
                `WDSC_IDX_TMRCFG: begin
                    o_s_axi_rdata <= {24'h000000, timer_config_register};
                end
                `WDSC_IDX_CFGWORD: begin
                    o_s_axi_rdata <= {24'h000000, device_configuration_word};
                end
                default: begin
                    // unmapped reads zero with an error
                    o_s_axi_rdata <= 32'h00000000;
                    o_s_axi_rresp <= `WDSC_RESP_SLVERR;
                end
            endcase
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== test/wdsc_top_monitor.sv
// Purpose: port-level checker for wdsc_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to wdsc_top at the foot of this file
`timescale 1ns/1ps
module wdsc_top_monitor #(
    parameter N_INT = 8,
    parameter N_PIN = 8
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_rst_n,
    // core strobes and wake sources
    input wire i_sleep_instruction,
    input wire i_watchdog_clear_instruction,
    input wire i_master_reset_pin_n,
    input wire [N_INT-1:0] i_int_flag,
    input wire [N_INT-1:0] i_int_enable,
    input wire i_global_interrupt_enable,
    // bus handshakes
    input wire i_s_axi_arvalid,
    input wire o_s_axi_arready,
    input wire o_s_axi_rvalid,
    input wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [1:0] o_s_axi_bresp,
    // core control and pins
    input wire o_wdt_reset,
    input wire o_master_reset,
    input wire o_sleeping,
    input wire o_osc_run,
    input wire o_prefetch,
    input wire o_sleep_nop,
    input wire o_wake,
    input wire o_wake_vector,
    input wire [N_PIN-1:0] o_pin_out,
    input wire [N_PIN-1:0] o_pin_oe_n
);
    // ----
    // common timing
    // ----
    default clocking mon_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    wire irq_hit = |(i_int_flag & i_int_enable); // enabled source pending

    // ----
    // sleep entry, no-op and wake
    // ----
    a_sleep_entry: assert property (i_sleep_instruction && !o_sleeping && !irq_hit &&
        i_master_reset_pin_n |=> o_sleeping && !o_osc_run && o_prefetch) else $error("sleep entry missed");
    a_sleep_as_nop: assert property (i_sleep_instruction && !o_sleeping && irq_hit &&
        i_master_reset_pin_n |=> o_sleep_nop && o_prefetch && !o_sleeping) else $error("sleep nop missed");
    a_irq_wake: assert property (o_sleeping && irq_hit && i_master_reset_pin_n |=> o_wake &&
        !o_sleeping && (o_wake_vector == $past(i_global_interrupt_enable))) else $error("irq wake wrong");
    a_osc_off: assert property (o_sleeping |-> !o_osc_run) else $error("oscillator runs asleep");
    // pins still once asleep for a full cycle
    a_pins_frozen: assert property (o_sleeping && $past(o_sleeping) |->
        $stable(o_pin_out) && $stable(o_pin_oe_n)) else $error("pins moved asleep");

    // ----
    // watchdog and reset pin
    // ----
    a_wdt_in_run: assert property (o_wdt_reset |-> !$past(o_sleeping)) else $error("reset from sleep");
    a_clear_holds: assert property (i_watchdog_clear_instruction |->
        ##2 (!o_wdt_reset) [*8]) else $error("time-out soon after clear");
    a_pin_reset: assert property (!i_master_reset_pin_n |=> o_master_reset && !o_wake)
        else $error("reset pin not followed");

    // ----
    // register bus answers
    // ----
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
        o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
endmodule

bind wdsc_top wdsc_top_monitor #(.N_INT(N_INT), .N_PIN(N_PIN)) mon_u (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_sleep_instruction(i_sleep_instruction),
    .i_watchdog_clear_instruction(i_watchdog_clear_instruction),
    .i_master_reset_pin_n(i_master_reset_pin_n),
    .i_int_flag(i_int_flag),
    .i_int_enable(i_int_enable),
    .i_global_interrupt_enable(i_global_interrupt_enable),
    .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready),
    .o_s_axi_rvalid(o_s_axi_rvalid),
    .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready),
    .o_s_axi_bresp(o_s_axi_bresp),
    .o_wdt_reset(o_wdt_reset),
    .o_master_reset(o_master_reset),
    .o_sleeping(o_sleeping),
    .o_osc_run(o_osc_run),
    .o_prefetch(o_prefetch),
    .o_sleep_nop(o_sleep_nop),
    .o_wake(o_wake),
    .o_wake_vector(o_wake_vector),
    .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n)
);

// ===== test/wdsc_top_bench.sv
// Purpose: self-checking bench for wdsc_top
// Assumes: watchdog period shortened to 16 cycles
// Notes: two runs, fuse cleared first, then fuse set
`timescale 1ns/1ps
module wdsc_top_bench;
    localparam PER = 16; // shortened watchdog period
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, clr, slp, rpin_n, genb;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] fuse, flag, ien, pout, poe_n;
    wire awready, wready, bvalid, arready, rvalid, wdt_rst, mrst, sleeping, osc_run;
    wire prefetch, nop, wake, wvec, pre_tmr;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [2:0] rate;
    wire [7:0] pin_out, pin_oe_n;
    int n_fail = 0;
    int tests_run = 0;
    int n_wdt = 0; // watchdog reset pulses seen

    wdsc_top #(.WDT_PERIOD_CYC(PER)) dut_u (
        .i_sys_clk(clk), .i_rst_n(rst_n),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .i_config_word(fuse), .i_watchdog_clear_instruction(clr), .i_sleep_instruction(slp),
        .i_master_reset_pin_n(rpin_n), .i_int_flag(flag), .i_int_enable(ien),
        .i_global_interrupt_enable(genb), .o_wdt_reset(wdt_rst), .o_master_reset(mrst),
        .o_sleeping(sleeping), .o_osc_run(osc_run), .o_prefetch(prefetch), .o_sleep_nop(nop),
        .o_wake(wake), .o_wake_vector(wvec), .o_prescaler_to_timer(pre_tmr),
        .o_prescaler_rate_select(rate), .i_port_out(pout), .i_port_oe_n(poe_n),
        .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n)
    );

    // ----
    // clock and pulse tally
    // ----
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (wdt_rst === 1'b1) n_wdt <= n_wdt + 1;

    // ----
    // comparison and closing
    // ----
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("counts: %0d compared, %0d mismatched", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // a bounded wait ran out: count it and stop
    task lost(input string nm);
        n_fail++;
        $display("mismatch %s expected answer seen none", nm);
        give_verdict();
    endtask

    // ----
    // bus cycles, sampled 1 ns after each edge
    // ----
    task wr(input [15:0] a, input [31:0] d, input [3:0] s, output logic [1:0] r);
        bit at, wt, bv, bt;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            #1;
            at = awvalid && awready;
            wt = wvalid && wready;
            bv = bvalid;
            bt = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
            if (bt) begin
                bready <= 1'b0;
                return;
            end
            // late bready on purpose: slave must hold its answer
            if (bv) bready <= 1'b1;
        end
        lost("write answer");
    endtask
    task rd(input [15:0] a, output logic [31:0] d, output logic [1:0] r);
        bit at, rt;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            #1;
            at = arvalid && arready;
            rt = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (at) arvalid <= 1'b0;
            if (rt) begin
                rready <= 1'b0;
                return;
            end
        end
        lost("read answer");
    endtask
    task rchk(input string nm, input [15:0] a, input [31:0] e, input [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, d, e);
        chk({nm, "_resp"}, r, er);
    endtask
    task wchk(input string nm, input [15:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        logic [1:0] r;
        wr(a, d, s, r);
        chk(nm, r, er);
    endtask

    // ----
    // core strobes, reset and event counting
    // ----
    // one-cycle strobe, returns just after its edge
    task strobe(input bit is_sleep);
        @(posedge clk);
        if (is_sleep) slp <= 1'b1;
        else clr <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        clr <= 1'b0;
        #1;
    endtask
    task count_to(input bit want_wake, output int n);
        for (n = 1; n <= 300; n++) begin
            @(posedge clk);
            #1;
            if ((want_wake ? wake : wdt_rst) === 1'b1) return;
        end
        lost("event count");
    endtask
    task do_reset(input [7:0] f);
        @(posedge clk);
        rst_n <= 1'b0;
        fuse <= f;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        int n, base;
        {rst_n, awvalid, wvalid, bready, arvalid, rready, clr, slp, genb} = '0;
        {awaddr, araddr, wdata, wstrb, flag, ien, pout, poe_n} = '0;
        rpin_n = 1'b1;
        fuse = 8'h00;
        do_reset(8'h00);
        rchk("status", 16'h000c, 32'h18, 2'h0);
        rchk("tmrcfg", 16'h0204, 32'h00, 2'h0);
        rchk("unmapped", 16'h0010, 32'h00, 2'h2);
        wchk("status_wr", 16'h000c, 32'hff, 4'h1, 2'h2);
        wchk("cfgword_wr", 16'h801c, 32'h04, 4'h1, 2'h2);
        wchk("tmrcfg_wr", 16'h0204, 32'h0b, 4'h1, 2'h0);
        wchk("tmrcfg_nostrb", 16'h0204, 32'h00, 4'h0, 2'h0);
        rchk("tmrcfg_rb", 16'h0204, 32'h0b, 2'h0);
        chk("to_timer", pre_tmr, 32'h0);
        chk("rate", rate, 32'h3);
        repeat (40) @(posedge clk);
        chk("wdt_off", n_wdt, 32'h0);
        $display("test registers done");
        @(posedge clk);
        flag <= 8'h01;
        ien <= 8'h01;
        strobe(1);
        chk("nop", nop, 32'h1);
        chk("nop_awake", sleeping, 32'h0);
        rchk("status_nop", 16'h000c, 32'h18, 2'h0);
        // irq wake, global enable set then clear
        for (int g = 1; g >= 0; g--) begin
            @(posedge clk);
            ien <= 8'h00;
            genb <= g[0];
            pout <= 8'h5a;
            poe_n <= 8'hf0;
            strobe(1);
            chk("asleep", sleeping, 32'h1);
            chk("osc_off", osc_run, 32'h0);
            chk("prefetch", prefetch, 32'h1);
            @(posedge clk);
            pout <= 8'ha5;
            poe_n <= 8'h0f;
            rchk("status_asleep", 16'h000c, 32'h10, 2'h0);
            chk("pin_hold", pin_out, 32'h5a);
            chk("oe_hold", pin_oe_n, 32'hf0);
            chk("masked_flag", sleeping, 32'h1);
            @(posedge clk);
            ien <= 8'h01;
            count_to(1, n);
            chk("irq_wake", n, 32'h1);
            chk("vector", wvec, g);
        end
        @(posedge clk);
        ien <= 8'h00;
        strobe(1);
        @(posedge clk);
        rpin_n <= 1'b0;
        @(posedge clk);
        #1;
        chk("pin_reset", mrst, 32'h1);
        chk("pin_wakes", sleeping, 32'h0);
        @(posedge clk);
        rpin_n <= 1'b1;
        $display("test sleep done");
        do_reset(8'h04);
        rchk("cfgword", 16'h801c, 32'h04, 2'h0);
        strobe(0);
        count_to(0, n);
        chk("plain_period", n, PER);
        rchk("status_timeout", 16'h000c, 32'h08, 2'h0);
        wchk("asg_on", 16'h0204, 32'h09, 4'h1, 2'h0);
        strobe(0);
        count_to(0, n);
        chk("divided_period", n, 2 * PER);
        rchk("asg_kept", 16'h0204, 32'h09, 2'h0);
        $display("test watchdog done");
        wchk("asg_off", 16'h0204, 32'h00, 4'h1, 2'h0);
        strobe(0);
        base = n_wdt;
        strobe(1);
        count_to(1, n);
        chk("wdt_wake", n, PER);
        chk("wdt_no_vector", wvec, 32'h0);
        chk("no_reset_asleep", n_wdt - base, 32'h0);
        rchk("status_wake", 16'h000c, 32'h00, 2'h0);
        $display("test watchdog wake done");
        give_verdict();
    end
endmodule
